// file: bench/flash_ctl_checker.sv
// Purpose: pin-level assertions for the flash bus controller
// Assumes: bound to flash_ctl, single clock domain
// Notes: counters stand in for long repetitions
`timescale 1ns/10ps
module flash_ctl_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ack,
    input wire logic interrupted_op,
    input wire logic fl_select_n,
    input wire logic fl_out_en_n,
    input wire logic fl_write_n,
    input wire logic fl_clear_n,
    input wire logic fl_id_voltage_en,
    input wire logic fl_dq_oe,
    input wire logic op_done_flag_n
);
    // ----
    // cycle counters
    // ----
    logic [15:0] low_cnt;
    logic [15:0] rel_cnt;
    logic [15:0] sel_cnt;
    default clocking dc @(posedge mclk); endclocking
    default disable iff rst;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) low_cnt <= 16'h0;
        else low_cnt <= fl_clear_n ? 16'h0 : low_cnt + 16'h1;
    end
    // saturates so a long idle never wraps into a false early read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) rel_cnt <= 16'hFFFF;
        else if (!fl_clear_n) rel_cnt <= 16'h0;
        else if (rel_cnt != 16'hFFFF) rel_cnt <= rel_cnt + 16'h1;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) sel_cnt <= 16'h0;
        else sel_cnt <= (!fl_select_n && !fl_out_en_n) ? sel_cnt + 16'h1 : 16'h0;
    end
    read_level_a: assert property (!fl_out_en_n |-> !fl_select_n && fl_write_n && !fl_dq_oe)
        else $error("read strobe without clean read levels");
    clear_quiet_a: assert property (!fl_clear_n |-> fl_select_n && fl_out_en_n && fl_write_n)
        else $error("bus cycle during clear pulse");
    clear_width_a: assert property ($rose(fl_clear_n) |-> low_cnt >= flash_ctl_pkg::CLEAR_PULSE_MIN_CYC)
        else $error("clear pulse too short");
    release_wait_a: assert property ($fell(fl_out_en_n) |->
        rel_cnt >= flash_ctl_pkg::CLEAR_RELEASE_TO_READ_CYC)
        else $error("read too soon after clear release");
    id_no_write_a: assert property (fl_id_voltage_en |-> fl_write_n && fl_clear_n)
        else $error("write or clear under id voltage");
    select_time_a: assert property (ack && !$past(fl_out_en_n) |-> sel_cnt >= flash_ctl_pkg::SELECT_ACCESS_CYC)
        else $error("read answered before select access time");
    retry_flag_a: assert property ($fell(fl_clear_n) && !op_done_flag_n |-> ##[0:300] interrupted_op)
        else $error("interrupted operation not flagged");
    clear_done_a: assert property ($rose(fl_clear_n) |-> ##[1:40] ack)
        else $error("clear not answered");
endmodule
bind flash_ctl flash_ctl_checker chk (.mclk(mclk), .rst(rst), .ack(ack), .interrupted_op(interrupted_op),
    .fl_select_n(fl_select_n), .fl_out_en_n(fl_out_en_n), .fl_write_n(fl_write_n), .fl_clear_n(fl_clear_n),
    .fl_id_voltage_en(fl_id_voltage_en), .fl_dq_oe(fl_dq_oe), .op_done_flag_n(op_done_flag_n));

// file: bench/flash_model.sv
// Purpose: behavioural boot-sector flash seen from its pins
// Assumes: pins sampled on mclk
// Notes: array byte is a fixed function of the address
`timescale 1ns/10ps
module flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h5A, // arbitrary value
    parameter int BUSY_CYC = 60,
    parameter int RECOVER_CYC = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [19:0] fl_addr,
    input wire logic fl_select_n,
    input wire logic fl_out_en_n,
    input wire logic fl_write_n,
    input wire logic fl_clear_n,
    input wire logic fl_id_voltage_en,
    output logic [7:0] dev_dq,
    output logic op_done_flag_n
);
    logic [15:0] busy;
    logic [15:0] acc;
    logic [7:0] last;
    logic [7:0] word;
    logic drive;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) busy <= 16'h0;
        else if (!fl_clear_n && busy > 16'(RECOVER_CYC)) busy <= 16'(RECOVER_CYC);
        else if (!fl_select_n && !fl_write_n && fl_clear_n && busy == 16'h0) busy <= 16'(BUSY_CYC);
        else if (busy != 16'h0) busy <= busy - 16'h1; // deselect does not stop it
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc <= 16'h0;
            last <= 8'h00;
        end else begin
            acc <= (!fl_select_n && !fl_out_en_n && fl_clear_n) ? acc + 16'h1 : 16'h0;
            last <= dev_dq;
        end
    end
    // data held from address only, so sleep never loses it
    always_comb begin
        case ({fl_addr[6], fl_addr[1], fl_addr[0]})
            3'h0: word = MAKER_CODE;
            3'h1: word = DEVICE_CODE;
            3'h2: word = {7'h0, fl_addr[16]};
            default: word = 8'h00;
        endcase
        if (!fl_id_voltage_en) word = fl_addr[7:0] ^ fl_addr[19:12];
    end
    assign drive = !fl_select_n && !fl_out_en_n && fl_clear_n && acc >= 16'(flash_ctl_pkg::SELECT_ACCESS_CYC - 1);
    assign dev_dq = drive ? word : ~last;
    assign op_done_flag_n = (busy == 16'h0);
endmodule

// file: bench/testbench.sv
// Purpose: self-checking bench for the flash bus controller
// Assumes: top-boot map, shortened ready count
// Notes: random addresses from a fixed seed
`timescale 1ns/10ps
module testbench;
    localparam logic [19:0] CORNER [8] = '{20'h00000, 20'hEFFFF, 20'hF0000, 20'hF7FFF,
        20'hF8000, 20'hF9FFF, 20'hFA000, 20'hFFFFF};
    logic mclk, rst, req_valid, req_ready, retry_pending, ack, interrupted_op, fl_dq_oe, op_done_flag_n;
    logic fl_select_n, fl_out_en_n, fl_write_n, fl_clear_n, fl_id_voltage_en;
    logic [19:0] fl_addr, a;
    logic [7:0] fl_dq_in, fl_dq_out, dev_dq, ev;
    logic [2:0] id;
    flash_ctl_pkg::req_t req;
    flash_ctl_pkg::resp_t resp, got;
    int num_errors, total_checks;
    integer seed;
    flash_ctl #(.TOP_BOOT(1'b1), .READY_CYC(20)) uut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .retry_pending(retry_pending), .ack(ack), .resp(resp),
        .interrupted_op(interrupted_op), .fl_addr(fl_addr), .fl_select_n(fl_select_n), .fl_out_en_n(fl_out_en_n),
        .fl_write_n(fl_write_n), .fl_clear_n(fl_clear_n), .fl_id_voltage_en(fl_id_voltage_en),
        .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .op_done_flag_n(op_done_flag_n));
    // long busy and recovery so the clear must wait on the done flag
    flash_model #(.BUSY_CYC(400), .RECOVER_CYC(140)) dev (.mclk(mclk), .rst(rst), .fl_addr(fl_addr),
        .fl_select_n(fl_select_n), .fl_out_en_n(fl_out_en_n), .fl_write_n(fl_write_n), .fl_clear_n(fl_clear_n),
        .fl_id_voltage_en(fl_id_voltage_en), .dev_dq(dev_dq), .op_done_flag_n(op_done_flag_n));
    assign fl_dq_in = fl_dq_oe ? fl_dq_out : dev_dq;
    // ----
    // tasks
    // ----
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic do_op(input flash_ctl_pkg::op_t op, input logic [19:0] addr);
        int n;
        n = 0;
        req = '{op: op, addr: addr, data: addr[7:0] ^ 8'h3C};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(posedge mclk) #1;
        @(posedge mclk) #1;
        req_valid = 1'b0;
        while (ack !== 1'b1 && n < 400) begin
            @(posedge mclk) #1;
            n++;
        end
        check("ack seen", 8'h1, {7'h0, ack});
        got = resp;
    endtask
    function automatic logic [4:0] exp_sector(input logic [19:0] x);
        if (x[19:16] != 4'hF) return {1'b0, x[19:16]};
        if (!x[15]) return 5'h0F;
        if (x[14]) return 5'h12;
        return x[13] ? 5'h11 : 5'h10;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        seed = 32'hB6F44216;
        {rst, req_valid, retry_pending, req, num_errors, total_checks} = '0;
        rst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            a = (i < 8) ? CORNER[i] : 20'($random(seed));
            do_op(flash_ctl_pkg::OP_READ, a);
            check("read data", a[7:0] ^ a[19:12], got.data);
            check("sector", {3'h0, exp_sector(a)}, {3'h0, got.sector});
        end
        $display("array reads done");
        for (int i = 0; i < 9; i++) begin
            id = (i % 3 == 0) ? flash_ctl_pkg::ID_MAKER :
                (i % 3 == 1) ? flash_ctl_pkg::ID_DEVICE : flash_ctl_pkg::ID_PROTECT;
            a = 20'($random(seed));
            a[6] = id[2];
            a[1:0] = id[1:0];
            do_op(flash_ctl_pkg::OP_ID_READ, a);
            ev = (i % 3 == 0) ? 8'hA5 : (i % 3 == 1) ? 8'h5A : {7'h0, a[16]};
            check("id byte", ev, got.data);
            if (i % 3 == 2) check("protect flag", {7'h0, a[16]}, {7'h0, got.protected_flag});
        end
        $display("id reads done");
        do_op(flash_ctl_pkg::OP_WRITE, 20'h12345);
        check("write data", 8'h45 ^ 8'h3C, fl_dq_out);
        check("write sector", 8'h01, {3'h0, got.sector});
        do_op(flash_ctl_pkg::OP_CLEAR, 20'h0);
        check("interrupted", 8'h1, {7'h0, interrupted_op});
        check("ready after clear", 8'h1, {7'h0, op_done_flag_n});
        retry_pending = 1'b1;
        repeat (3) @(posedge mclk) #1;
        retry_pending = 1'b0;
        check("retry cleared", 8'h0, {7'h0, interrupted_op});
        do_op(flash_ctl_pkg::OP_CLEAR, 20'h0);
        check("idle clear", 8'h0, {7'h0, interrupted_op});
        do_op(flash_ctl_pkg::OP_READ, 20'hFA0C3);
        check("read after clear", 8'hC3 ^ 8'hFA, got.data);
        $display("clear tests done");
        give_verdict();
    end
endmodule

// file: rtl/flash_ctl.sv
// Purpose: host-side controller driving the flash chip select, output enable, write strobe and clear pins
// Assumes: flash pins sampled synchronously to mclk; elevated id voltage switched by an external driver
// Notes: one request at a time; ack pulses for one cycle when the answer is ready
`timescale 1ns/10ps

// Notes on behaviour
// - host reissues program or erase interrupted by a clear; the controller only flags it on interrupted_op until retry_pending
// - after clear release host waits the release interval before reading
// - elevated id voltage with a6, a1, a0 selects the identifier byte
// - protection check: sector on top bits, a1 high a0 low, 00h unprotected
// - array read drives select and output enable low, write strobe high
module flash_ctl #(
    parameter bit TOP_BOOT = 1'b1,
    parameter int READY_CYC = flash_ctl_pkg::READY_EMBEDDED_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire flash_ctl_pkg::req_t req,
    input wire logic retry_pending,
    output logic ack,
    output flash_ctl_pkg::resp_t resp,
    output logic interrupted_op,
    output logic [19:0] fl_addr,
    output logic fl_select_n,
    output logic fl_out_en_n,
    output logic fl_write_n,
    output logic fl_clear_n,
    output logic fl_id_voltage_en,
    input wire logic [7:0] fl_dq_in,
    output logic [7:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic op_done_flag_n
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WRITE = 3'b010,
        ST_CLEAR = 3'b011,
        ST_RECOVER = 3'b100,
        ST_RELEASE = 3'b101
    } state_t;

    state_t state;
    logic [flash_ctl_pkg::CNT_W-1:0] cnt;
    logic [19:0] last_addr;
    logic [flash_ctl_pkg::CNT_W-1:0] stable_cnt;
    logic asleep;
    logic busy_seen;
    logic [4:0] next_sector;

    localparam logic [flash_ctl_pkg::CNT_W-1:0] CNT_ACC = flash_ctl_pkg::CNT_W'(flash_ctl_pkg::SELECT_ACCESS_CYC);
    localparam logic [flash_ctl_pkg::CNT_W-1:0] CNT_WR = flash_ctl_pkg::CNT_W'(flash_ctl_pkg::ADDRESS_ACCESS_CYC);
    localparam logic [flash_ctl_pkg::CNT_W-1:0] CNT_CLR = flash_ctl_pkg::CNT_W'(flash_ctl_pkg::CLEAR_PULSE_MIN_CYC);
    localparam logic [flash_ctl_pkg::CNT_W-1:0] CNT_REL =
        flash_ctl_pkg::CNT_W'(flash_ctl_pkg::CLEAR_RELEASE_TO_READ_CYC);
    localparam logic [flash_ctl_pkg::CNT_W-1:0] CNT_RDY = flash_ctl_pkg::CNT_W'(READY_CYC);
    localparam logic [flash_ctl_pkg::CNT_W-1:0] CNT_SLEEP = flash_ctl_pkg::CNT_W'(flash_ctl_pkg::SLEEP_CYC);

    assign req_ready = (state == ST_IDLE);

    // ------------------------------------------------------------
    // sector decode
    // ------------------------------------------------------------
    always_comb begin
        next_sector = 5'h0;
        if (TOP_BOOT) begin
            if (fl_addr[19:16] != 4'hF) begin
                next_sector = {1'b0, fl_addr[19:16]};
            end else if (!fl_addr[15]) begin
                next_sector = 5'h0F;
            end else if (!fl_addr[14]) begin
                next_sector = fl_addr[13] ? 5'h11 : 5'h10;
            end else begin
                next_sector = flash_ctl_pkg::SECTOR_COUNT - 5'h1;
            end
        end else begin
            if (fl_addr[19:16] != 4'h0) begin
                next_sector = 5'(fl_addr[19:16]) + 5'h3;
            end else if (fl_addr[15]) begin
                next_sector = 5'h03;
            end else if (fl_addr[14]) begin
                next_sector = fl_addr[13] ? 5'h02 : 5'h01;
            end else begin
                next_sector = 5'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // sleep tracking: address held stable long enough
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_addr <= 20'h0;
            stable_cnt <= '0;
            asleep <= 1'b0;
        end else begin
            last_addr <= fl_addr;
            if (fl_addr != last_addr) begin
                stable_cnt <= '0;
                asleep <= 1'b0;
            end else if (stable_cnt >= CNT_SLEEP) begin
                asleep <= 1'b1;
            end else begin
                stable_cnt <= stable_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // bus sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= '0;
            fl_addr <= 20'h0;
            fl_select_n <= 1'b1;
            fl_out_en_n <= 1'b1;
            fl_write_n <= 1'b1;
            fl_clear_n <= 1'b1;
            fl_id_voltage_en <= 1'b0;
            fl_dq_out <= 8'h00;
            fl_dq_oe <= 1'b0;
            ack <= 1'b0;
            resp <= '0;
            busy_seen <= 1'b0;
            interrupted_op <= 1'b0;
        end else begin
            ack <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    fl_select_n <= 1'b1;
                    fl_out_en_n <= 1'b1;
                    fl_write_n <= 1'b1;
                    fl_dq_oe <= 1'b0;
                    if (req_valid) begin
                        fl_addr <= req.addr;
                        cnt <= '0;
                        unique case (req.op)
                            flash_ctl_pkg::OP_READ, flash_ctl_pkg::OP_ID_READ: begin
                                // id read relies on the sector bits being on top and a6/a1/a0 set by caller
                                fl_id_voltage_en <= (req.op == flash_ctl_pkg::OP_ID_READ);
                                fl_select_n <= 1'b0;
                                fl_out_en_n <= 1'b0;
                                state <= ST_READ;
                            end
                            flash_ctl_pkg::OP_WRITE: begin
                                fl_select_n <= 1'b0;
                                fl_write_n <= 1'b0;
                                fl_dq_out <= req.data;
                                fl_dq_oe <= 1'b1;
                                state <= ST_WRITE;
                            end
                            flash_ctl_pkg::OP_CLEAR: begin
                                busy_seen <= !op_done_flag_n;
                                interrupted_op <= !op_done_flag_n;
                                fl_clear_n <= 1'b0;
                                state <= ST_CLEAR;
                            end
                        endcase
                    end else if (retry_pending) begin
                        interrupted_op <= 1'b0;
                    end
                end
                ST_READ: begin
                    // full select access even if the flash slept: it came from standby
                    if (cnt >= CNT_ACC) begin
                        resp.data <= fl_dq_in;
                        resp.sector <= next_sector;
                        resp.protected_flag <= fl_id_voltage_en &&
                            (fl_dq_in != flash_ctl_pkg::UNPROTECTED_CODE);
                        ack <= 1'b1;
                        fl_select_n <= 1'b1;
                        fl_out_en_n <= 1'b1;
                        fl_id_voltage_en <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (cnt >= CNT_WR) begin
                        fl_write_n <= 1'b1;
                        fl_select_n <= 1'b1;
                        fl_dq_oe <= 1'b0;
                        resp.sector <= next_sector;
                        ack <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_CLEAR: begin
                    if (cnt >= CNT_CLR) begin
                        cnt <= '0;
                        state <= ST_RECOVER;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_RECOVER: begin
                    // embedded abort: hold clear until flag rises or time runs out
                    if ((busy_seen && op_done_flag_n) || cnt >= CNT_RDY || !busy_seen) begin
                        fl_clear_n <= 1'b1;
                        cnt <= '0;
                        state <= ST_RELEASE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_RELEASE: begin
                    if (cnt >= CNT_REL) begin
                        ack <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    logic unused_sleep;
    assign unused_sleep = asleep;
endmodule

// file: rtl/flash_ctl_pkg.sv
// Purpose: shared constants and types for the boot-sector flash bus controller
// Assumes: mclk at 250 MHz (4 ns period)
// Notes: times in ns, counts derived from the clock period
package flash_ctl_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int ADDRESS_ACCESS_NS = 90;
    localparam int SELECT_ACCESS_NS = 90;
    localparam int SLEEP_EXTRA_NS = 30;
    localparam int CLEAR_PULSE_MIN_NS = 500;
    localparam int CLEAR_RELEASE_TO_READ_NS = 50;
    localparam int READY_EMBEDDED_NS = 20000;
    localparam int ADDRESS_ACCESS_CYC = (ADDRESS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_CYC = (ADDRESS_ACCESS_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_PULSE_MIN_CYC = (CLEAR_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_RELEASE_TO_READ_CYC = (CLEAR_RELEASE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_EMBEDDED_CYC = READY_EMBEDDED_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // identifier address pattern (a6, a1, a0)
    // ------------------------------------------------------------
    localparam logic [2:0] ID_MAKER = 3'h0;
    localparam logic [2:0] ID_DEVICE = 3'h1;
    localparam logic [2:0] ID_PROTECT = 3'h2;
    localparam logic [7:0] UNPROTECTED_CODE = 8'h00;

    // ------------------------------------------------------------
    // sector map
    // ------------------------------------------------------------
    localparam logic [4:0] SECTOR_COUNT = 5'h13;

    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_CLEAR = 2'b10,
        OP_ID_READ = 2'b11
    } op_t;

    typedef struct packed {
        op_t op;
        logic [19:0] addr;
        logic [7:0] data;
    } req_t;

    typedef struct packed {
        logic [7:0] data;
        logic [4:0] sector;
        logic protected_flag;
    } resp_t;
endpackage
